// [verilog/rsu_pkg.sv]
package rsu_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS         = 50;
    localparam int STARTUP_DELAY_US      = 4100;
    localparam int STARTUP_DELAY_CYCLES  = (STARTUP_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int UV_MIN_DROP_NS        = 2000;
    localparam int UV_MIN_DROP_CYCLES    = (UV_MIN_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURNOFF_HOLD_CYCLES   = 4;
    localparam int WDOG_OSC_KHZ          = 1000;

    // ********************************************************
    // watchdog period table
    // ********************************************************
    localparam int               WDOG_CNT_W   = 22;
    localparam logic [21:0]      WDOG_BASE    = 22'h004000;
    localparam logic [21:0]      WDOG_ONE     = 22'h000001;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [6:0] OFF_WATCHDOG_CONTROL   = 7'h21;
    localparam logic [6:0] OFF_RESET_CAUSE_STATUS = 7'h34;
    localparam logic [6:0] DATA_SPACE_SHIFT       = 7'h20;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED          = 8'h00;

    localparam int BIT_TURNOFF  = 4;
    localparam int BIT_ENABLE   = 3;
    localparam int BIT_TEST     = 4;
    localparam int BIT_WDOG     = 3;
    localparam int BIT_UV       = 2;
    localparam int BIT_PIN      = 1;
    localparam int BIT_SUPPLY   = 0;

    typedef struct packed {
        logic       watchdog_turnoff_enable;
        logic       watchdog_enable_bit;
        logic [2:0] watchdog_period_select;
    } rsu_wdog_ctrl_t;

    typedef struct packed {
        logic test_port_reset_flag;
        logic watchdog_cause_flag;
        logic undervoltage_cause_flag;
        logic pin_reset_flag;
        logic supply_on_flag;
    } rsu_cause_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       data_space;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rsu_io_req_t;

endpackage

// [verilog/rsu_sync.sv]
`timescale 1ns/100ps
module rsu_sync #(
    parameter logic IDLE = 1'b0
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // a change counts only once the second and third stages agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1    <= IDLE;
            s2    <= IDLE;
            s3    <= IDLE;
            level <= IDLE;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

// [verilog/rsu_wdog.sv]
`timescale 1ns/100ps
module rsu_wdog
    import rsu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       osc_level,
    input  wire logic       clear,
    input  wire logic       enable,
    input  wire logic [2:0] period,
    output logic            expire
);
    logic [WDOG_CNT_W-1:0] count;
    logic                  osc_last;
    wire                   osc_rise = osc_level & ~osc_last;
    wire [WDOG_CNT_W-1:0]  limit    = (WDOG_BASE << period) - WDOG_ONE;
    wire                   at_limit = (count == limit);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count    <= '0;
            osc_last <= 1'b0;
            expire   <= 1'b0;
        end else if (ce) begin
            osc_last <= osc_level;
            expire   <= 1'b0;
            if (clear) begin
                count <= '0;
            end else if (osc_rise) begin
                if (at_limit && enable) begin
                    count  <= '0;
                    expire <= 1'b1;
                end else begin
                    count <= count + WDOG_ONE;
                end
            end
        end
    end
endmodule

// [verilog/rsu_top.sv]
`timescale 1ns/100ps
// Overview of operation
// - five reset causes merge into one reset
// - low pin resets even without clock
// - pin release waits for startup delay
// - supply loss resets at once, delayed release
// - test reset register one holds reset
// - enabled undervoltage resets after filter, delayed release
// - short undervoltage dips are ignored
// - watchdog expiry gives one-clock pulse, delayed release
// - bandgap on for detector, comparator, converter
// - watchdog counts separate oscillator ticks
// - watchdog cleared by restart, disable, reset
// - eight periods; expiry resets the device
// - period is 16K cycles doubled per code
// - enable cleared only with turnoff; auto-clear four
// - bit 4 marks test-port reset cause
// - bits 3..1 mark watchdog, undervoltage, pin
// - bit 0 marks power-on, software-clear only
// - registers at I/O offset, data space +0x20
// - delay counter stretches reset after sources
module rsu_top
    import rsu_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DELAY_CYCLES,
    parameter int UV_MIN_CYCLES  = UV_MIN_DROP_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               ce,
    input  wire logic               pin_reset_n,
    input  wire logic               undervoltage_detector,
    input  wire logic               undervoltage_detect_fuse,
    input  wire logic               test_reset_register,
    input  wire logic               watchdog_osc,
    input  wire logic               watchdog_restart,
    input  wire logic               comparator_bandgap_select,
    input  wire logic               converter_enable,
    input  wire rsu_pkg::rsu_io_req_t io_req,
    output logic [7:0]              io_rdata,
    output logic                    internal_reset,
    output logic                    bandgap_enable
);
    import rsu_pkg::*;

    // ********************************************************
    // parameter checks
    // ********************************************************
    localparam int DLY_W = $clog2(STARTUP_CYCLES + 1);
    localparam int UVF_W = $clog2(UV_MIN_CYCLES + 1);

    if (STARTUP_CYCLES < 1) begin : g_bad_startup
        $error("startup delay must be at least one cycle");
    end
    if (UV_MIN_CYCLES < 1) begin : g_bad_uv
        $error("undervoltage filter must be at least one cycle");
    end

    // ********************************************************
    // asynchronous reset paths
    // ********************************************************
    // pin low clears without a clock; supply loss via resetn
    wire arst_n = resetn & pin_reset_n;

    // ********************************************************
    // input synchronisers
    // ********************************************************
    logic pin_level;
    logic uv_level;
    logic test_level;
    logic osc_level;

    rsu_sync #(.IDLE(1'b1)) u_sync_pin (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (pin_reset_n),
        .level  (pin_level)
    );

    rsu_sync #(.IDLE(1'b0)) u_sync_uv (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (undervoltage_detector),
        .level  (uv_level)
    );

    rsu_sync #(.IDLE(1'b0)) u_sync_test (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (test_reset_register),
        .level  (test_level)
    );

    rsu_sync #(.IDLE(1'b0)) u_sync_osc (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (watchdog_osc),
        .level  (osc_level)
    );

    // ********************************************************
    // undervoltage drop filter
    // ********************************************************
    logic [UVF_W-1:0] uv_count;
    logic             uv_active;
    wire              uv_armed   = undervoltage_detect_fuse & uv_level;
    wire              uv_long    = (uv_count == UVF_W'(UV_MIN_CYCLES));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            uv_count  <= '0;
            uv_active <= 1'b0;
        end else if (ce) begin
            if (!uv_armed) begin
                uv_count  <= '0;
                uv_active <= 1'b0;
            end else if (!uv_long) begin
                uv_count <= uv_count + UVF_W'(1);
            end else begin
                uv_active <= 1'b1;
            end
        end
    end

    // ********************************************************
    // watchdog control register
    // ********************************************************
    rsu_wdog_ctrl_t      wctl;
    logic [2:0]          toe_count;
    logic                wdog_expire;

    wire io_hit_wctl = io_req.data_space
                     ? (io_req.addr == OFF_WATCHDOG_CONTROL + DATA_SPACE_SHIFT)
                     : (io_req.addr == OFF_WATCHDOG_CONTROL);
    wire io_hit_stat = io_req.data_space
                     ? (io_req.addr == OFF_RESET_CAUSE_STATUS + DATA_SPACE_SHIFT)
                     : (io_req.addr == OFF_RESET_CAUSE_STATUS);
    wire wr_wctl     = io_req.wr & io_hit_wctl;
    wire wr_stat     = io_req.wr & io_hit_stat;

    // a zero to the enable only lands while turn-off is already open
    wire next_wde    = io_req.wdata[BIT_ENABLE]
                     | (wctl.watchdog_enable_bit & ~wctl.watchdog_turnoff_enable);
    wire toe_expired = (toe_count == 3'h1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wctl      <= rsu_wdog_ctrl_t'(WATCHDOG_CONTROL_RESET[4:0]);
            toe_count <= 3'h0;
        end else if (ce) begin
            if (internal_reset) begin
                wctl      <= rsu_wdog_ctrl_t'(WATCHDOG_CONTROL_RESET[4:0]);
                toe_count <= 3'h0;
            end else if (wr_wctl) begin
                wctl.watchdog_enable_bit     <= next_wde;
                wctl.watchdog_period_select  <= io_req.wdata[2:0];
                wctl.watchdog_turnoff_enable <= io_req.wdata[BIT_TURNOFF];
                toe_count <= io_req.wdata[BIT_TURNOFF] ? 3'(TURNOFF_HOLD_CYCLES) : 3'h0;
            end else if (toe_count != 3'h0) begin
                toe_count <= toe_count - 3'h1;
                if (toe_expired) begin
                    wctl.watchdog_turnoff_enable <= 1'b0;
                end
            end
        end
    end

    // ********************************************************
    // watchdog counter
    // ********************************************************
    wire wdog_clear = watchdog_restart | ~wctl.watchdog_enable_bit | internal_reset;

    rsu_wdog u_wdog (
        .clk       (clk),
        .resetn    (arst_n),
        .ce        (ce),
        .osc_level (osc_level),
        .clear     (wdog_clear),
        .enable    (wctl.watchdog_enable_bit),
        .period    (wctl.watchdog_period_select),
        .expire    (wdog_expire)
    );

    // ********************************************************
    // reset merge and startup delay
    // ********************************************************
    wire pin_active = ~pin_level;
    wire any_source = pin_active | uv_active | test_level | wdog_expire;

    logic [DLY_W-1:0] delay_count;
    wire              delay_running = (delay_count != '0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delay_count    <= DLY_W'(STARTUP_CYCLES);
            internal_reset <= 1'b1;
        end else if (ce) begin
            if (any_source) begin
                delay_count <= DLY_W'(STARTUP_CYCLES);
            end else if (delay_running) begin
                delay_count <= delay_count - DLY_W'(1);
            end
            internal_reset <= any_source | delay_running;
        end
    end

    // ********************************************************
    // reset cause flags
    // ********************************************************
    rsu_cause_t cause;
    rsu_cause_t cause_set;
    rsu_cause_t cause_keep;

    // pin flag needs a running clock while the pin is low
    assign cause_set.test_port_reset_flag    = test_level;
    assign cause_set.watchdog_cause_flag     = wdog_expire;
    assign cause_set.undervoltage_cause_flag = uv_active;
    assign cause_set.pin_reset_flag          = pin_active;
    assign cause_set.supply_on_flag          = 1'b0;
    assign cause_keep = wr_stat ? (cause & rsu_cause_t'(io_req.wdata[4:0])) : cause;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cause <= rsu_cause_t'(5'h01);
        end else if (ce) begin
            cause <= cause_keep | cause_set;
        end
    end

    // ********************************************************
    // read port and bandgap
    // ********************************************************
    wire [7:0] rd_wctl = {3'h0, wctl};
    wire [7:0] rd_stat = {3'h0, cause};
    wire [7:0] rd_mux  = io_hit_wctl ? rd_wctl : (io_hit_stat ? rd_stat : READ_UNMAPPED);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_rdata       <= READ_UNMAPPED;
            bandgap_enable <= 1'b0;
        end else if (ce) begin
            if (io_req.rd) begin
                io_rdata <= rd_mux;
            end
            bandgap_enable <= undervoltage_detect_fuse
                            | comparator_bandgap_select
                            | converter_enable;
        end
    end

endmodule

// [verification/rsu_checker.sv]
`timescale 1ns/100ps
module rsu_checker
    import rsu_pkg::*;
#(
    parameter int STARTUP_CYCLES = 20,
    parameter int UV_MIN_CYCLES  = 3
) (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 ce,
    input wire logic                 pin_reset_n,
    input wire logic                 undervoltage_detector,
    input wire logic                 undervoltage_detect_fuse,
    input wire logic                 test_reset_register,
    input wire logic                 comparator_bandgap_select,
    input wire logic                 converter_enable,
    input wire rsu_pkg::rsu_io_req_t io_req,
    input wire logic [7:0]           io_rdata,
    input wire logic                 internal_reset,
    input wire logic                 bandgap_enable
);
    // ********************************************************
    // helpers and properties
    // ********************************************************
    logic [7:0] quiet;
    wire  [6:0] io_off = io_req.data_space ? io_req.addr - DATA_SPACE_SHIFT : io_req.addr;
    wire        io_hit = io_off == OFF_WATCHDOG_CONTROL || io_off == OFF_RESET_CAUSE_STATUS;
    wire        uv_on  = undervoltage_detect_fuse && undervoltage_detector;

    // undervoltage left out: its filter makes the quiet span fuzzy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet <= 8'h00;
        end else if (!pin_reset_n || test_reset_register) begin
            quiet <= 8'h00;
        end else if (quiet != 8'hFF) begin
            quiet <= quiet + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pin_reset_now: assert property (!pin_reset_n |-> internal_reset)
        else $error("pin low without reset");
    a_test_reg_holds: assert property (test_reset_register [*6] |-> internal_reset)
        else $error("test register one without reset");
    a_uv_long_resets: assert property (uv_on [*8] |-> ##[0:3] internal_reset)
        else $error("long undervoltage without reset");
    a_release_delay: assert property ($fell(internal_reset) |-> quiet >= STARTUP_CYCLES)
        else $error("reset released before startup delay");
    a_bandgap_or: assert property ($past(resetn) && $past(ce) |-> bandgap_enable ==
        $past(undervoltage_detect_fuse || comparator_bandgap_select || converter_enable))
        else $error("bandgap enable mismatch");
    a_rdata_top_zero: assert property (io_rdata[7:5] == 3'h0)
        else $error("read data upper bits set");
    a_unmapped_zero: assert property ($past(io_req.rd && ce && !io_hit) |-> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_stands: assert property (!$past(io_req.rd && ce) |-> $stable(io_rdata))
        else $error("read data changed without read");

    cover property ($fell(internal_reset));
    cover property (io_req.wr && io_hit);
    cover property (uv_on [*8]);
endmodule

bind rsu_top rsu_checker #(.STARTUP_CYCLES(STARTUP_CYCLES), .UV_MIN_CYCLES(UV_MIN_CYCLES))
    rsu_checker_inst (.clk(clk), .resetn(resetn), .ce(ce), .pin_reset_n(pin_reset_n),
    .undervoltage_detector(undervoltage_detector), .test_reset_register(test_reset_register),
    .undervoltage_detect_fuse(undervoltage_detect_fuse), .converter_enable(converter_enable),
    .comparator_bandgap_select(comparator_bandgap_select), .io_req(io_req),
    .io_rdata(io_rdata), .internal_reset(internal_reset), .bandgap_enable(bandgap_enable));

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import rsu_pkg::*;
    localparam int SC = 20;
    localparam int OSC_CLKS = 4;
    logic        clk, resetn, ce, pin_n, uv, fuse, test_rst, osc, restart, cmp_bg, conv;
    logic        internal_reset, bandgap_enable;
    logic [7:0]  io_rdata, per;
    logic [6:0]  a;
    rsu_io_req_t io_req;
    int          err_count, n_compared, n, osc_half;

    rsu_top #(.STARTUP_CYCLES(SC), .UV_MIN_CYCLES(3)) rsu_top_inst (
        .clk(clk), .resetn(resetn), .ce(ce), .pin_reset_n(pin_n),
        .undervoltage_detector(uv), .undervoltage_detect_fuse(fuse),
        .test_reset_register(test_rst), .watchdog_osc(osc), .watchdog_restart(restart),
        .comparator_bandgap_select(cmp_bg), .converter_enable(conv), .io_req(io_req),
        .io_rdata(io_rdata), .internal_reset(internal_reset), .bandgap_enable(bandgap_enable));

    // ********************************************************
    // clocks and tasks
    // ********************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // 1 MHz oscillator, sped up later so an expiry fits the run;
    // half periods stay multiples of 50 ns, on falling clk edges
    initial begin
        osc = 1'b0;
        osc_half = 500;
        forever #(osc_half) osc = ~osc;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // clocks per watchdog timeout with the sped-up oscillator
    function automatic int wdog_clocks(input int sel);
        return (int'(WDOG_BASE) << sel) * OSC_CLKS;
    endfunction
    // one-cycle strobe, then one idle cycle so read data has landed
    task automatic bus(input logic w, input logic ds, input logic [6:0] ad, input logic [7:0] d);
        io_req = '{wr: w, rd: ~w, data_space: ds, addr: ad, wdata: d};
        @(negedge clk);
        io_req = '0;
        @(negedge clk);
    endtask
    task automatic rd(input logic ds, input logic [6:0] ad, input logic [7:0] exp);
        bus(1'b0, ds, ad, 8'h00);
        check(io_rdata, exp);
    endtask
    task automatic wait_rel();
        n = 0;
        while (internal_reset !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(8'(n >= SC && n <= SC + 8), 8'h01);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        err_count++;
        stop_test();
    end

    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        {resetn, uv, fuse, test_rst, restart, cmp_bg, conv} = 7'h00;
        pin_n = 1'b1;
        ce = 1'b1;
        io_req = '0;
        err_count = 0;
        n_compared = 0;
        per = 8'($urandom(32'hCE97));
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        wait_rel();
        rd(1'b0, OFF_RESET_CAUSE_STATUS, 8'h01);
        rd(1'b1, 7'h54, 8'h01);
        rd(1'b0, OFF_WATCHDOG_CONTROL, WATCHDOG_CONTROL_RESET);
        rd(1'b0, 7'h41, READ_UNMAPPED);
        rd(1'b1, 7'h21, READ_UNMAPPED);
        for (int i = 0; i < 6; i++) begin
            a = 7'($urandom % 32);
            bus(1'b1, i[0], a, 8'($urandom));
            rd(i[0], a, READ_UNMAPPED);
        end
        bus(1'b1, 1'b0, 7'h34, 8'hFF);
        rd(1'b0, 7'h34, 8'h01);
        bus(1'b1, 1'b1, 7'h54, 8'h00);
        rd(1'b0, 7'h34, 8'h00);
        $display("test registers done");
        pin_n = 1'b0;
        #1;
        check(8'(internal_reset), 8'h01);
        @(negedge clk);
        bus(1'b1, 1'b0, 7'h21, 8'h08);
        pin_n = 1'b1;
        repeat (10) @(negedge clk);
        test_rst = 1'b1;
        repeat (30) @(negedge clk);
        check(8'(internal_reset), 8'h01);
        test_rst = 1'b0;
        wait_rel();
        rd(1'b0, 7'h34, 8'h12);
        rd(1'b0, 7'h21, 8'h00);
        bus(1'b1, 1'b0, 7'h34, 8'h00);
        $display("test pin and test port done");
        fuse = 1'b1;
        uv = 1'b1;
        repeat (2) @(negedge clk);
        uv = 1'b0;
        repeat (10) @(negedge clk);
        check(8'(internal_reset), 8'h00);
        uv = 1'b1;
        repeat (12) @(negedge clk);
        check(8'(internal_reset), 8'h01);
        uv = 1'b0;
        wait_rel();
        rd(1'b0, 7'h34, 8'h04);
        fuse = 1'b0;
        uv = 1'b1;
        repeat (12) @(negedge clk);
        check(8'(internal_reset), 8'h00);
        uv = 1'b0;
        for (int i = 0; i < 12; i++) begin
            {fuse, cmp_bg, conv} = (i < 8) ? 3'(i) : 3'($urandom);
            repeat (2) @(negedge clk);
            check(8'(bandgap_enable), 8'(fuse | cmp_bg | conv));
        end
        fuse = 1'b0;
        $display("test undervoltage and bandgap done");
        osc_half = OSC_CLKS * 25;
        per = 8'($urandom % 8);
        bus(1'b1, 1'b0, 7'h21, 8'h08 | per);
        rd(1'b0, 7'h21, 8'h08 | per);
        bus(1'b1, 1'b0, 7'h21, 8'h00);
        rd(1'b0, 7'h21, 8'h08);
        bus(1'b1, 1'b1, 7'h41, 8'h18);
        repeat (6) @(negedge clk);
        rd(1'b0, 7'h21, 8'h08);
        bus(1'b1, 1'b1, 7'h41, 8'h18);
        bus(1'b1, 1'b0, 7'h21, 8'h00);
        rd(1'b0, 7'h21, 8'h00);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        rd(1'b0, 7'h34, 8'h04);
        // frozen clock enable drops a clearing write
        ce = 1'b0;
        bus(1'b1, 1'b0, 7'h34, 8'h00);
        ce = 1'b1;
        rd(1'b0, 7'h34, 8'h04);
        bus(1'b1, 1'b0, 7'h21, 8'h08);
        repeat (wdog_clocks(0) - 8) @(negedge clk);
        check(8'(internal_reset), 8'h00);
        n = 0;
        while (internal_reset !== 1'b1 && n < 16) begin
            @(negedge clk);
            n++;
        end
        check(8'(internal_reset), 8'h01);
        wait_rel();
        rd(1'b0, 7'h34, 8'h0C);
        rd(1'b0, 7'h21, 8'h00);
        resetn = 1'b0;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        wait_rel();
        rd(1'b0, 7'h34, 8'h01);
        $display("test watchdog control and supply done");
        stop_test();
    end
endmodule
